// *** hw/completion_boot_pkg.sv ***
// constants shared by the completion signalling and boot autoload logic
package completion_boot_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 20;
    localparam int POR_WAIT_US     = 400;
    localparam int POR_WAIT_CYC    = POR_WAIT_US * CLK_MHZ;
    // ------------------------------------------------------------
    // buffer sizes in 16-bit words
    // ------------------------------------------------------------
    localparam int BUF_AW          = 10;
    localparam int WORD_W          = 16;
    localparam int BOOT_MAIN_WORDS = 512;
    localparam int BOOT_SPARE_WORDS = 16;
    localparam int BOOT_WORDS      = BOOT_MAIN_WORDS + BOOT_SPARE_WORDS;
    localparam int DATA_WORDS      = 1024;
    localparam int NUM_DATA_BUF    = 2;
    // ------------------------------------------------------------
    // host buffer address map
    // ------------------------------------------------------------
    localparam logic [15:0] BOOT_MAIN_BASE  = 16'h0000;
    localparam logic [15:0] BOOT_MAIN_LAST  = 16'h01FF;
    localparam logic [15:0] BOOT_SPARE_BASE = 16'h8000;
    localparam logic [15:0] BOOT_SPARE_LAST = 16'h800F;
    localparam logic [15:0] DATA0_BASE      = 16'h0400;
    localparam logic [15:0] DATA1_BASE      = 16'h0800;
    // ------------------------------------------------------------
    // array addresses of the boot code and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] BOOT_ARRAY_BASE = 16'h0000;
    localparam logic        INT_BIT_RST     = 1'b0;
    // ------------------------------------------------------------
    // command kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CMD_LOAD, CMD_PROGRAM, CMD_ERASE, CMD_NONE} cmd_kind_e;
endpackage

// *** hw/buf_port_if.sv ***
// write and read port of one buffer ram
`timescale 1ns/1ps
interface buf_port_if;
    logic                                       we;
    logic [completion_boot_pkg::BUF_AW-1:0]     waddr;
    logic [completion_boot_pkg::WORD_W-1:0]     wdata;
    logic [completion_boot_pkg::BUF_AW-1:0]     raddr;
    logic [completion_boot_pkg::WORD_W-1:0]     rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** hw/buffer_ram.sv ***
// single-port-write, registered-read buffer ram
`timescale 1ns/1ps
module buffer_ram #(
    parameter int DEPTH = 1024
) (
    input  wire logic i_clk_sys,
    buf_port_if.mem   port
);
    logic [completion_boot_pkg::WORD_W-1:0] mem_r [DEPTH];
    logic [completion_boot_pkg::WORD_W-1:0] rdata_r;

    always_ff @(posedge i_clk_sys) begin
        if (port.we && (int'(port.waddr) < DEPTH)) begin
            mem_r[port.waddr] <= port.wdata;
        end
        rdata_r <= (int'(port.raddr) < DEPTH) ? mem_r[port.raddr] : 16'h0000;
    end

    assign port.rdata = rdata_r;
endmodule

// *** hw/completion_boot.sv ***
// completion pin, status bit, power-on boot copy and load into buffer rams
`timescale 1ns/1ps
module completion_boot #(
    parameter int POR_WAIT = completion_boot_pkg::POR_WAIT_CYC
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_supply_low,
    input  wire logic        i_hardware_reset_pin_n,
    input  wire logic        i_int_pol_inv,
    input  wire logic        i_int_bit_clr,
    input  wire logic        i_cmd_valid,
    input  wire logic [1:0]  i_cmd_kind,
    input  wire logic [15:0] i_cmd_array_addr,
    input  wire logic        i_cmd_buf_sel,
    input  wire logic        i_op_done,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_rd_addr,
    input  wire logic        i_array_valid,
    input  wire logic [15:0] i_array_data,
    output logic             o_int_out,
    output logic             o_int_oe_n,
    output logic             o_int_bit,
    output logic             o_busy,
    output logic             o_array_req,
    output logic [15:0]      o_array_addr,
    output logic             o_rd_valid,
    output logic [15:0]      o_rd_data
);
    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_POR_WAIT, ST_BOOT_COPY, ST_BOOT_HOLD, ST_IDLE,
                              ST_LOAD, ST_OP} state_e;
    state_e      state_r;
    state_e      state_nxt;
    logic [13:0] por_cnt_r;
    logic [9:0]  idx_r;
    logic        buf_sel_r;
    logic [15:0] array_base_r;
    logic        int_bit_r;
    logic        int_oe_n_r;
    logic        busy_r;
    logic        array_req_r;
    logic [15:0] array_addr_r;
    logic        rd_p1_r;
    logic [1:0]  rd_sel_r;
    logic        rd_valid_r;
    logic [15:0] rd_data_r;

    buf_port_if boot_port ();
    buf_port_if data_port [completion_boot_pkg::NUM_DATA_BUF] ();

    // ------------------------------------------------------------
    // host address decode
    // ------------------------------------------------------------
    function automatic logic [1:0] region(input logic [15:0] a);
        if (a <= completion_boot_pkg::BOOT_MAIN_LAST) begin
            region = 2'h0;
        end else if (a >= completion_boot_pkg::BOOT_SPARE_BASE &&
                     a <= completion_boot_pkg::BOOT_SPARE_LAST) begin
            region = 2'h0;
        end else if (a >= completion_boot_pkg::DATA0_BASE &&
                     a < completion_boot_pkg::DATA1_BASE) begin
            region = 2'h1;
        end else if (a >= completion_boot_pkg::DATA1_BASE && a < 16'h0C00) begin
            region = 2'h2;
        end else begin
            region = 2'h3;
        end
    endfunction

    wire       rd_spare  = (i_rd_addr >= completion_boot_pkg::BOOT_SPARE_BASE);
    wire [9:0] boot_ridx = rd_spare ? (10'h200 + {6'h00, i_rd_addr[3:0]})
                                    : i_rd_addr[9:0];
    wire [1:0] rd_region = region(i_rd_addr);

    // ------------------------------------------------------------
    // copy engine decode
    // ------------------------------------------------------------
    wire       copying   = (state_r == ST_BOOT_COPY) || (state_r == ST_LOAD);
    wire       word_in   = copying && i_array_valid && !i_supply_low;
    wire [9:0] boot_last = 10'(completion_boot_pkg::BOOT_WORDS - 1);
    wire [9:0] data_last = 10'(completion_boot_pkg::DATA_WORDS - 1);
    wire       boot_end  = word_in && (state_r == ST_BOOT_COPY) && (idx_r == boot_last);
    wire       load_end  = word_in && (state_r == ST_LOAD) && (idx_r == data_last);
    wire       cmd_take  = i_cmd_valid && (state_r == ST_IDLE) && !i_supply_low;
    wire       op_end    = (state_r == ST_OP) && i_op_done;
    wire       set_done  = load_end || op_end ||
                           (state_r == ST_BOOT_HOLD && i_hardware_reset_pin_n) ||
                           (boot_end && i_hardware_reset_pin_n);
    wire       int_nxt   = set_done ? 1'b1 : (i_int_bit_clr ? 1'b0 : int_bit_r);
    wire       pin_level = int_nxt ^ i_int_pol_inv;

    assign boot_port.we    = word_in && (state_r == ST_BOOT_COPY);
    assign boot_port.waddr = idx_r;
    assign boot_port.wdata = i_array_data;
    assign boot_port.raddr = boot_ridx;

    genvar g;
    generate
        for (g = 0; g < completion_boot_pkg::NUM_DATA_BUF; g++) begin : g_data
            assign data_port[g].we    = word_in && (state_r == ST_LOAD) &&
                                        (buf_sel_r == 1'(g));
            assign data_port[g].waddr = idx_r;
            assign data_port[g].wdata = i_array_data;
            assign data_port[g].raddr = i_rd_addr[9:0];
            buffer_ram #(.DEPTH(completion_boot_pkg::DATA_WORDS)) u_data (
                .i_clk_sys (i_clk_sys),
                .port      (data_port[g])
            );
        end
    endgenerate

    buffer_ram #(.DEPTH(completion_boot_pkg::BOOT_WORDS)) u_boot (
        .i_clk_sys (i_clk_sys),
        .port      (boot_port)
    );

    wire [15:0] rd_mux = (rd_sel_r == 2'h0) ? boot_port.rdata :
                         (rd_sel_r == 2'h1) ? data_port[0].rdata :
                         (rd_sel_r == 2'h2) ? data_port[1].rdata : 16'h0000;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_POR_WAIT: begin
                if (int'(por_cnt_r) >= POR_WAIT - 1 && !i_supply_low) begin
                    state_nxt = ST_BOOT_COPY;
                end
            end
            ST_BOOT_COPY: begin
                if (i_supply_low) begin
                    state_nxt = ST_POR_WAIT;
                end else if (boot_end) begin
                    state_nxt = i_hardware_reset_pin_n ? ST_IDLE : ST_BOOT_HOLD;
                end
            end
            ST_BOOT_HOLD: begin
                if (i_hardware_reset_pin_n) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cmd_take) begin
                    state_nxt = (i_cmd_kind == 2'(completion_boot_pkg::CMD_LOAD)) ? ST_LOAD
                              : (i_cmd_kind == 2'(completion_boot_pkg::CMD_NONE)) ? ST_IDLE
                              : ST_OP;
                end
            end
            ST_LOAD: begin
                if (i_supply_low) begin
                    state_nxt = ST_IDLE;
                end else if (load_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_OP: begin
                if (i_supply_low || op_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // sequencing registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_r      <= ST_POR_WAIT;
            por_cnt_r    <= 14'h0000;
            idx_r        <= 10'h000;
            buf_sel_r    <= 1'b0;
            array_base_r <= completion_boot_pkg::BOOT_ARRAY_BASE;
        end else begin
            state_r   <= state_nxt;
            por_cnt_r <= (state_r == ST_POR_WAIT && !i_supply_low) ? por_cnt_r + 14'h0001
                                                                    : 14'h0000;
            idx_r     <= (state_nxt != state_r) ? 10'h000 : (word_in ? idx_r + 10'h001 : idx_r);
            if (cmd_take) begin
                buf_sel_r    <= i_cmd_buf_sel;
                array_base_r <= i_cmd_array_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // completion pin and status
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            int_bit_r  <= completion_boot_pkg::INT_BIT_RST;
            int_oe_n_r <= 1'b0;
            busy_r     <= 1'b1;
        end else begin
            int_bit_r  <= int_nxt;
            int_oe_n_r <= pin_level;
            busy_r     <= (state_nxt != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // array requests and host reads
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            array_req_r  <= 1'b0;
            array_addr_r <= 16'h0000;
            rd_p1_r      <= 1'b0;
            rd_sel_r     <= 2'h3;
            rd_valid_r   <= 1'b0;
            rd_data_r    <= 16'h0000;
        end else begin
            array_req_r  <= (state_nxt == ST_BOOT_COPY) || (state_nxt == ST_LOAD);
            array_addr_r <= ((state_nxt == ST_BOOT_COPY) ? completion_boot_pkg::BOOT_ARRAY_BASE
                                                         : array_base_r) +
                            {6'h00, ((state_nxt != state_r) ? 10'h000 :
                                     (word_in ? idx_r + 10'h001 : idx_r))};
            if (state_nxt == ST_LOAD && state_r == ST_IDLE) begin
                array_addr_r <= i_cmd_array_addr;
            end
            rd_p1_r    <= i_rd;
            rd_sel_r   <= rd_region;
            rd_valid_r <= rd_p1_r;
            rd_data_r  <= rd_p1_r ? rd_mux : rd_data_r;
        end
    end

    assign o_int_out    = 1'b0;
    assign o_int_oe_n   = int_oe_n_r;
    assign o_int_bit    = int_bit_r;
    assign o_busy       = busy_r;
    assign o_array_req  = array_req_r;
    assign o_array_addr = array_addr_r;
    assign o_rd_valid   = rd_valid_r;
    assign o_rd_data    = rd_data_r;
endmodule

// *** verif/array_model.sv ***
// array side model handing out one word per requested address
`timescale 1ns/1ps
module array_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_slow,
    output logic             o_valid,
    output logic [15:0]      o_data
);
    logic [15:0] last_r = 16'h0000;
    int          gap    = 0;
    initial o_valid = 1'b0;
    initial o_data = 16'h0000;
    always @(posedge i_clk_sys) begin
        if (i_req && !o_valid && gap == 0) begin
            o_valid <= 1'b1;
            o_data  <= i_addr ^ 16'h5A3C;
            last_r  <= i_addr ^ 16'h5A3C;
            gap     <= i_slow ? $urandom_range(5, 0) : 0;
        end else begin
            o_valid <= 1'b0;
            o_data  <= ~last_r;       // no stale word after release
            gap     <= (gap > 0) ? gap - 1 : 0;
        end
    end
endmodule

// *** verif/completion_boot_props.sv ***
// checker for the completion pin and boot copy ports
`timescale 1ns/1ps
module completion_boot_props #(
    parameter int POR_WAIT = completion_boot_pkg::POR_WAIT_CYC
) (
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_supply_low,
    input wire logic        i_hardware_reset_pin_n,
    input wire logic        i_int_pol_inv,
    input wire logic        i_cmd_valid,
    input wire logic [1:0]  i_cmd_kind,
    input wire logic        i_op_done,
    input wire logic        i_rd,
    input wire logic        i_array_valid,
    input wire logic        o_int_out,
    input wire logic        o_int_oe_n,
    input wire logic        o_int_bit,
    input wire logic        o_busy,
    input wire logic        o_array_req,
    input wire logic [15:0] o_array_addr,
    input wire logic        o_rd_valid
);
    logic        prog_r;
    logic        boot_done_r;
    logic [15:0] por_cnt_r;
    logic [10:0] take_cnt_r;
    wire         take    = i_cmd_valid && !o_busy && !i_supply_low;
    wire         is_op   = i_cmd_kind == 2'h1 || i_cmd_kind == 2'h2;
    wire         por_run = !boot_done_r && !o_array_req && por_cnt_r != 16'hFFFF;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            prog_r      <= 1'b0;
            boot_done_r <= 1'b0;
            por_cnt_r   <= 16'h0000;
            take_cnt_r  <= 11'h000;
        end else begin
            prog_r      <= take ? is_op : prog_r;
            boot_done_r <= boot_done_r | o_int_bit;
            por_cnt_r   <= i_supply_low ? 16'h0000 : por_cnt_r + {15'h0000, por_run};
            take_cnt_r  <= o_array_req ? take_cnt_r + {10'h000, i_array_valid} : 11'h000;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_pin_drain: assert property (o_int_out == 1'b0)
        else $error("completion pin data not low");
    a_pin_level: assert property (!$past(i_rst) |->
        o_int_oe_n == (o_int_bit ^ $past(i_int_pol_inv)))
        else $error("pin level does not follow status and polarity");
    a_read_lat: assert property (!$past(i_rst, 2) |-> o_rd_valid == $past(i_rd, 2))
        else $error("read answer not two cycles after request");
    a_done_sets_bit: assert property (i_op_done && prog_r && o_busy && !i_supply_low |=>
        o_int_bit && !o_busy)
        else $error("finished operation did not set status");
    a_low_blocks: assert property (i_cmd_valid && !o_busy && i_supply_low |=> !o_busy)
        else $error("command taken at low supply");
    a_low_aborts: assert property (i_supply_low && prog_r && o_busy |=>
        !o_busy && !$rose(o_int_bit))
        else $error("operation survived low supply");
    a_por_wait: assert property ($rose(o_array_req) && !boot_done_r |->
        por_cnt_r >= POR_WAIT && por_cnt_r <= POR_WAIT + 3)
        else $error("boot copy start time wrong");
    a_copy_bit: assert property ($fell(o_array_req) && !boot_done_r |->
        o_int_bit == $past(i_hardware_reset_pin_n))
        else $error("cold start status wrong at end of copy");
    a_boot_base: assert property ($rose(o_array_req) && !boot_done_r |->
        o_array_addr == 16'h0000)
        else $error("boot copy does not start at array base");
    a_addr_step: assert property (o_array_req && i_array_valid |=>
        !o_array_req || o_array_addr == $past(o_array_addr) + 16'h0001)
        else $error("array address did not advance by one");
    a_copy_len: assert property ($fell(o_array_req) && !$past(i_supply_low) |->
        take_cnt_r == (boot_done_r ? 11'h400 : 11'h210))
        else $error("copy word count wrong");
endmodule
bind completion_boot completion_boot_props #(.POR_WAIT(POR_WAIT)) completion_boot_props_i (
    .i_clk_sys              (i_clk_sys),
    .i_rst                  (i_rst),
    .i_supply_low           (i_supply_low),
    .i_hardware_reset_pin_n (i_hardware_reset_pin_n),
    .i_int_pol_inv          (i_int_pol_inv),
    .i_cmd_valid            (i_cmd_valid),
    .i_cmd_kind             (i_cmd_kind),
    .i_op_done              (i_op_done),
    .i_rd                   (i_rd),
    .i_array_valid          (i_array_valid),
    .o_int_out              (o_int_out),
    .o_int_oe_n             (o_int_oe_n),
    .o_int_bit              (o_int_bit),
    .o_busy                 (o_busy),
    .o_array_req            (o_array_req),
    .o_array_addr           (o_array_addr),
    .o_rd_valid             (o_rd_valid)
);

// *** verif/test_completion_boot.sv ***
// self-checking bench for the completion pin and boot copy block
`timescale 1ns/1ps
module test_completion_boot;
    localparam int PW = 20;
    logic        clk = 1'b0, rst = 1'b1, low = 1'b0, pin_n = 1'b0, inv = 1'b0, clr = 1'b0;
    logic        cv = 1'b0, cbs = 1'b0, done = 1'b0, rd = 1'b0, slow = 1'b0;
    logic [1:0]  kind = 2'h0;
    logic [15:0] caddr = 16'h0000, raddr = 16'h0000, adata, aaddr, rdata;
    logic        av, iout, oe_n, ibit, busy, areq, rvld;
    int          bad_count = 0, check_count = 0;
    int          exp_q[$];
    int          ld_base[2] = '{0, 0};
    always #25 clk = ~clk;
    completion_boot #(.POR_WAIT(PW)) completion_boot_i (
        .i_clk_sys(clk), .i_rst(rst), .i_supply_low(low), .i_hardware_reset_pin_n(pin_n),
        .i_int_pol_inv(inv), .i_int_bit_clr(clr), .i_cmd_valid(cv), .i_cmd_kind(kind),
        .i_cmd_array_addr(caddr), .i_cmd_buf_sel(cbs), .i_op_done(done), .i_rd(rd),
        .i_rd_addr(raddr), .i_array_valid(av), .i_array_data(adata), .o_int_out(iout),
        .o_int_oe_n(oe_n), .o_int_bit(ibit), .o_busy(busy), .o_array_req(areq),
        .o_array_addr(aaddr), .o_rd_valid(rvld), .o_rd_data(rdata));
    array_model array_model_i (.i_clk_sys(clk), .i_req(areq), .i_addr(aaddr),
        .i_slow(slow), .o_valid(av), .o_data(adata));
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp, input string m);
        chk_word({15'h0000, got}, {15'h0000, exp}, m);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        while (s !== v && k < lim) begin
            @(negedge clk);
            k++;
        end
        chk_flag(s, v, "wait");
    endtask
    function automatic logic [15:0] exp_rd(input logic [15:0] a);
        int o;
        o = -1;
        if (a <= 16'h01FF) o = a;
        if (a >= 16'h8000 && a <= 16'h800F) o = a - 16'h8000 + 16'h0200;
        if (a >= 16'h0400 && a <= 16'h0BFF) o = ld_base[(a >> 10) - 1] + (a & 16'h03FF);
        return (o < 0) ? 16'h0000 : (o[15:0] ^ 16'h5A3C);
    endfunction
    task automatic rd_one(input logic [15:0] a);
        rd = 1'b1;
        raddr = a;
        exp_q.push_back(exp_rd(a));
        tick(1);
    endtask
    always @(negedge clk) begin
        if (rvld === 1'b1) begin
            if (exp_q.size() == 0) chk_flag(1'b1, 1'b0, "unasked read");
            else chk_word(rdata, exp_q.pop_front(), "read data");
        end
    end
    task automatic issue(input logic [1:0] k, input logic [15:0] a, input logic s);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        chk_flag(ibit, 1'b0, "status cleared");
        chk_flag(oe_n, inv, "pin at start");
        cv = 1'b1;
        kind = k;
        caddr = a;
        cbs = s;
        tick(1);
        cv = 1'b0;
    endtask
    task automatic op_run(input logic [1:0] k, input int d);
        issue(k, 16'h0000, 1'b0);
        chk_flag(busy, 1'b1, "op running");
        tick(d);
        chk_flag(ibit, 1'b0, "bit low in op");
        done = 1'b1;
        tick(1);
        done = 1'b0;
        chk_flag(ibit, 1'b1, "bit at end");
        chk_flag(oe_n, ~inv, "pin at end");
        chk_flag(busy, 1'b0, "idle at end");
    endtask
    task automatic load(input logic [15:0] a, input logic s);
        issue(completion_boot_pkg::CMD_LOAD, a, s);
        wait_for(busy, 1'b0, 10000);
        chk_flag(ibit, 1'b1, "load done");
        ld_base[s] = a;
        rd_one((s ? 16'h0800 : 16'h0400));
        rd_one((s ? 16'h0BFF : 16'h07FF));
        for (int i = 0; i < 6; i++) rd_one((s ? 16'h0800 : 16'h0400) + 16'($urandom_range(1023, 0)));
        rd = 1'b0;
        tick(3);
    endtask
    initial begin
        void'($urandom(32'h00382522));
        tick(16);
        rst = 1'b0;
        chk_flag(ibit, 1'b0, "reset status");
        chk_flag(oe_n, 1'b0, "reset pin");
        wait_for(areq, 1'b1, PW + 10);
        wait_for(areq, 1'b0, 4000);
        tick(4);
        chk_flag(ibit, 1'b0, "held by reset pin");
        pin_n = 1'b1;
        tick(2);
        chk_flag(ibit, 1'b1, "cold start done");
        chk_flag(oe_n, 1'b1, "pin idles high");
        $display("cold start test done");
        for (int i = 0; i < 16'h0210; i++) rd_one(i < 16'h0200 ? i[15:0] : i[15:0] + 16'h7E00);
        for (int i = 0; i < 8; i++) rd_one(16'h8010 + 16'($urandom_range(16'h7FEF, 0)));
        rd_one(16'h0200);
        rd_one(16'h03FF);
        rd_one(16'h0C00);
        rd = 1'b0;
        tick(3);
        $display("boot read test done");
        op_run(completion_boot_pkg::CMD_PROGRAM, $urandom_range(40, 1));
        inv = 1'b1;
        tick(1);
        chk_flag(oe_n, 1'b0, "inverted idle");
        op_run(completion_boot_pkg::CMD_ERASE, $urandom_range(40, 1));
        inv = 1'b0;
        $display("operation test done");
        load(16'($urandom), 1'b0);
        slow = 1'b1;
        load(16'($urandom), 1'b1);
        slow = 1'b0;
        $display("load test done");
        issue(completion_boot_pkg::CMD_NONE, 16'h0000, 1'b0);
        chk_flag(busy, 1'b0, "no-op ignored");
        low = 1'b1;
        issue(completion_boot_pkg::CMD_PROGRAM, 16'h0000, 1'b0);
        chk_flag(busy, 1'b0, "blocked at low supply");
        low = 1'b0;
        issue(completion_boot_pkg::CMD_PROGRAM, 16'h0000, 1'b0);
        tick(3);
        low = 1'b1;
        tick(1);
        low = 1'b0;
        tick(1);
        chk_flag(busy, 1'b0, "aborted op idle");
        chk_flag(ibit, 1'b0, "aborted op no bit");
        pin_n = 1'b0;
        tick(2);
        low = 1'b1;
        tick(2);
        $display("supply test done");
        low = 1'b0;
        pin_n = 1'b1;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        chk_flag(busy, 1'b1, "busy after reset");
        chk_flag(ibit, 1'b0, "status after reset");
        wait_for(areq, 1'b1, PW + 10);
        wait_for(areq, 1'b0, 4000);
        chk_flag(ibit, 1'b1, "bit at copy end");
        chk_flag(oe_n, 1'b1, "pin at copy end");
        chk_flag(busy, 1'b0, "idle at copy end");
        rd_one(16'h0123);
        rd_one(16'h8007);
        rd = 1'b0;
        tick(3);
        $display("restart test done");
        results();
    end
    initial begin
        #(50 * 40000);
        bad_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        results();
    end
endmodule
